// file: ixa_exec.sv
// The placing of the registers and register access over Wishbone were decided locally.
`timescale 1ns/1ps
`include "ixa_defs.svh"
// Operation
// RULE_01 - A skip that is taken costs two instruction cycles, one that is not costs one.
// RULE_02 - Any write of a new value into the program counter low byte costs two cycles.
// RULE_03 - Timeout and power-down flags clear only after both pre-clears run back to back.
// RULE_04 - Add with carry to accumulator stores accumulator plus memory plus carry there.
// RULE_05 - Add with carry to memory stores accumulator plus memory plus carry in memory.
// RULE_06 - Plain adds sum accumulator and memory without carry, to either destination.
// RULE_07 - Add immediate sums accumulator and instruction operand into the accumulator.
// RULE_08 - Every add updates overflow, zero, half carry and carry from its result.
// RULE_09 - AND to accumulator with memory or immediate touches only the zero flag.
// RULE_10 - AND to memory writes the result back to memory and touches only zero.
// RULE_11 - A call pushes the address after it and then loads the target address.
// RULE_12 - A call always runs, takes two cycles and leaves every flag alone.
// RULE_13 - Clear memory writes zero to the addressed byte.
// RULE_14 - Zero flag marks an all-zero result; carry takes the carry out of bit 7.

module ixa_exec
	import ixa_pkg::*;
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);

	ixa_state_t r;
	ixa_state_t n;
	ixa_op_t op;
	logic [7:0] arg;
	logic [7:0] mval;
	logic [7:0] wadr;
	logic exec;
	ixa_alu_if alu_bus ();

	// Merge write data into an old word by byte lanes.
	function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] v;
		v = old;
		for (int i = 0; i < 4; i++)
		begin
			if (sel[i])
			begin
				v[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return v;
	endfunction : lane_merge

	// Data space read: RAM, the program counter low byte, or zero elsewhere.
	function automatic logic [7:0] mem_rd(input ixa_state_t s, input logic [7:0] a);
		logic [7:0] v;
		v = 8'h00;
		if (a == `IXA_PCL_ADDR)
		begin
			v = s.pc[7:0];
		end
		else if (a < 8'(`IXA_MEM_WORDS))
		begin
			v = s.mem[a[6:0]];
		end
		return v;
	endfunction : mem_rd

	// Instruction fields and the operand fetched from data space.
	assign op = ixa_op_t'(r.ir[`IXA_IR_OP_MSB:`IXA_IR_OP_LSB]);
	assign arg = r.ir[`IXA_IR_ARG_MSB:`IXA_IR_ARG_LSB];
	assign mval = mem_rd(r, arg);
	assign exec = (r.st == ST_EXEC);
	assign wadr = {wb_adr_i[7:2], 2'b00};

	// Adder inputs: immediate forms take the operand, only the carry forms take carry in.
	assign alu_bus.a = r.accumulator;
	assign alu_bus.b = (op == OP_ADDI || op == OP_ANDI) ? arg : mval; // RULE_07
	assign alu_bus.cin = (op == OP_ADC || op == OP_ADCM) ? r.carry_flag : 1'b0; // RULE_06
	assign alu_bus.is_and = (op == OP_AND || op == OP_ANDI || op == OP_ANDM);

	ixa_alu u_alu (
		.alu(alu_bus)
	);

	// Next-state logic for the bus port and the instruction sequence.
	always_comb
	begin : p_next
		logic two;
		logic wr_mem;
		logic [7:0] wr_val;
		logic [`IXA_PC_W-1:0] pc_seq;
		two = 1'b0;
		wr_mem = 1'b0;
		wr_val = 8'h00;
		pc_seq = r.pc + `IXA_PC_W'(1);
		n = r;
		n.ack = 1'b0;
		// Bus accesses wait while an instruction runs, so they never race it.
		if (wb_cyc_i && wb_stb_i && !r.ack && r.st == ST_IDLE)
		begin
			n.ack = 1'b1;
			n.dat = 32'h0000_0000;
			case (wadr)
				`IXA_OFS_INSTR:
				begin
					n.dat = r.ir;
					if (wb_we_i)
					begin
						n.ir = lane_merge(r.ir, wb_dat_i, wb_sel_i);
						n.st = ST_EXEC;
					end
				end
				`IXA_OFS_STATUS:
				begin
					n.dat = {23'h0, 1'b0, 2'h0, r.timeout_flag, r.powerdown_flag,
						r.overflow_flag, r.zero_flag, r.aux_carry_flag, r.carry_flag};
					if (wb_we_i && wb_sel_i[0])
					begin
						n.carry_flag = wb_dat_i[`IXA_ST_C];
						n.aux_carry_flag = wb_dat_i[`IXA_ST_AC];
						n.zero_flag = wb_dat_i[`IXA_ST_Z];
						n.overflow_flag = wb_dat_i[`IXA_ST_OV];
						n.powerdown_flag = wb_dat_i[`IXA_ST_PDF];
						n.timeout_flag = wb_dat_i[`IXA_ST_TO];
					end
				end
				`IXA_OFS_ACC:
				begin
					n.dat = {24'h0, r.accumulator};
					if (wb_we_i && wb_sel_i[0])
					begin
						n.accumulator = wb_dat_i[7:0];
					end
				end
				`IXA_OFS_PC:
				begin
					n.dat = {21'h0, r.pc};
					if (wb_we_i)
					begin
						n.pc = `IXA_PC_W'(lane_merge({21'h0, r.pc}, wb_dat_i, wb_sel_i));
					end
				end
				`IXA_OFS_CYCLES:
				begin
					n.dat = {30'h0, r.cycles};
				end
				`IXA_OFS_STACK:
				begin
					n.dat = {13'h0, r.depth, 5'h0, r.stack[0]};
				end
				`IXA_OFS_MEMADDR:
				begin
					n.dat = {24'h0, r.maddr};
					if (wb_we_i && wb_sel_i[0])
					begin
						n.maddr = wb_dat_i[7:0];
					end
				end
				`IXA_OFS_MEMDATA:
				begin
					n.dat = {24'h0, mem_rd(r, r.maddr)};
					if (wb_we_i && wb_sel_i[0])
					begin
						if (r.maddr == `IXA_PCL_ADDR)
						begin
							n.pc = {r.pc[`IXA_PC_W-1:8], wb_dat_i[7:0]};
						end
						else if (r.maddr < 8'(`IXA_MEM_WORDS))
						begin
							n.mem[r.maddr[6:0]] = wb_dat_i[7:0];
						end
					end
				end
				default:
				begin
					n.dat = 32'h0000_0000;
				end
			endcase
		end
		// Effects of the instruction land at the end of its first cycle.
		if (exec)
		begin
			n.pc = pc_seq;
			n.wdt = WDT_NONE;
			case (op)
				OP_ADC, OP_ADD, OP_ADDI:
				begin
					n.accumulator = alu_bus.res; // RULE_04
				end
				OP_ADCM, OP_ADDM:
				begin
					wr_mem = 1'b1; // RULE_05
					wr_val = alu_bus.res;
				end
				OP_AND, OP_ANDI:
				begin
					n.accumulator = alu_bus.res; // RULE_09
				end
				OP_ANDM:
				begin
					wr_mem = 1'b1; // RULE_10
					wr_val = alu_bus.res;
				end
				OP_CLRM:
				begin
					wr_mem = 1'b1; // RULE_13
					wr_val = 8'h00;
				end
				OP_CALL:
				begin
					// Deepest entry falls off when the stack is already full.
					for (int i = `IXA_STACK_DEPTH - 1; i > 0; i--)
					begin
						n.stack[i] = r.stack[i-1];
					end
					n.stack[0] = pc_seq; // RULE_11
					n.pc = r.ir[`IXA_IR_TGT_MSB:`IXA_IR_TGT_LSB];
					if (r.depth != 3'(`IXA_STACK_DEPTH))
					begin
						n.depth = r.depth + 3'h1;
					end
					two = 1'b1; // RULE_12
				end
				OP_SZ:
				begin
					if (mval == 8'h00)
					begin
						n.pc = pc_seq + `IXA_PC_W'(1);
						two = 1'b1; // RULE_01
					end
				end
				OP_WDT1, OP_WDT2:
				begin
					// Repeating one pre-clear is harmless; only the alternate pair clears.
					n.wdt = (op == OP_WDT1) ? WDT_FIRST : WDT_SECOND;
					if ((op == OP_WDT1 && r.wdt == WDT_SECOND) ||
						(op == OP_WDT2 && r.wdt == WDT_FIRST))
					begin
						n.timeout_flag = 1'b0; // RULE_03
						n.powerdown_flag = 1'b0;
					end
				end
				default:
				begin
					n.wdt = WDT_NONE;
				end
			endcase
			// Add and AND flag updates; other operations leave carry, half carry, zero and overflow alone.
			if (op == OP_ADC || op == OP_ADCM || op == OP_ADD || op == OP_ADDI || op == OP_ADDM)
			begin
				n.carry_flag = alu_bus.cout; // RULE_08
				n.aux_carry_flag = alu_bus.acout;
				n.overflow_flag = alu_bus.ovf;
				n.zero_flag = (alu_bus.res == 8'h00); // RULE_14
			end
			else if (alu_bus.is_and)
			begin
				n.zero_flag = (alu_bus.res == 8'h00); // RULE_09
			end
			// A memory result aimed at the program counter low byte redirects flow.
			if (wr_mem)
			begin
				if (arg == `IXA_PCL_ADDR)
				begin
					n.pc = {r.pc[`IXA_PC_W-1:8], wr_val};
					two = 1'b1; // RULE_02
				end
				else if (arg < 8'(`IXA_MEM_WORDS))
				begin
					n.mem[arg[6:0]] = wr_val;
				end
			end
			n.cycles = two ? `IXA_CYC_TWO : `IXA_CYC_ONE;
			n.st = two ? ST_EXEC2 : ST_IDLE;
		end
		else if (r.st == ST_EXEC2)
		begin
			n.st = ST_IDLE;
		end
	end

	// Single state register with synchronous reset.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			r <= '0;
			r.st <= ST_IDLE;
			r.wdt <= WDT_NONE;
			r.accumulator <= `IXA_RST_ACC;
			r.pc <= `IXA_RST_PC;
			r.timeout_flag <= `IXA_RST_FLAG;
			r.powerdown_flag <= `IXA_RST_FLAG;
		end
		else
		begin
			r <= n;
		end
	end

	assign wb_ack_o = r.ack;
	assign wb_dat_o = r.dat;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Second instruction cycle followed by return to idle.
	sequence s_two_cycles;
		(r.st == ST_EXEC2) ##1 (r.st == ST_IDLE);
	endsequence

	sequence s_one_cycle;
		(r.st == ST_IDLE) && (r.cycles == `IXA_CYC_ONE);
	endsequence

	chk_skip_taken: assert property (exec && op == OP_SZ && mval == 8'h00 |=> s_two_cycles) // RULE_01
		else $error("taken skip did not take two cycles");
	chk_skip_not_taken: assert property (exec && op == OP_SZ && mval != 8'h00 |=> s_one_cycle) // RULE_01
		else $error("untaken skip did not take one cycle");
	chk_pcl_write: assert property (exec && (op == OP_ADDM || op == OP_CLRM) && arg == `IXA_PCL_ADDR
		|=> r.pc[7:0] == $past(op == OP_CLRM ? 8'h00 : alu_bus.res) ##0 s_two_cycles) // RULE_02
		else $error("program counter low write wrong or not two cycles");
	chk_wdt_pair: assert property (exec && ((op == OP_WDT2 && r.wdt == WDT_FIRST) ||
		(op == OP_WDT1 && r.wdt == WDT_SECOND)) |=> !r.timeout_flag && !r.powerdown_flag) // RULE_03
		else $error("pre-clear pair did not clear the flags");
	chk_wdt_repeat: assert property (exec && ((op == OP_WDT1 && r.wdt != WDT_SECOND) ||
		(op == OP_WDT2 && r.wdt != WDT_FIRST))
		|=> $stable(r.timeout_flag) && $stable(r.powerdown_flag)) // RULE_03
		else $error("lone pre-clear changed the flags");
	chk_adc_acc: assert property (exec && op == OP_ADC
		|=> r.accumulator == 8'($past(r.accumulator) + $past(mval) + {7'h0, $past(r.carry_flag)})) // RULE_04
		else $error("add with carry to accumulator wrong");
	chk_adcm_mem: assert property (exec && op == OP_ADCM && arg < 8'(`IXA_MEM_WORDS)
		|=> r.mem[$past(arg[6:0])] ==
		8'($past(r.accumulator) + $past(mval) + {7'h0, $past(r.carry_flag)})) // RULE_05
		else $error("add with carry to memory wrong");
	chk_add_flags: assert property (exec && (op == OP_ADD || op == OP_ADDI)
		|=> r.carry_flag == $past(alu_bus.cout) && r.zero_flag == (r.accumulator == 8'h00)
		&& r.overflow_flag == $past(alu_bus.ovf)) // RULE_08
		else $error("add flags wrong");
	chk_and_flags: assert property (exec && alu_bus.is_and
		|=> $stable(r.carry_flag) && $stable(r.aux_carry_flag) && $stable(r.overflow_flag)
		&& r.zero_flag == ($past(r.accumulator & alu_bus.b) == 8'h00)) // RULE_10
		else $error("AND changed a flag other than zero");
	chk_call_push: assert property (exec && op == OP_CALL
		|=> r.stack[0] == $past(r.pc) + `IXA_PC_W'(1) && $stable(r.carry_flag) && $stable(r.zero_flag)
		##0 s_two_cycles) // RULE_11
		else $error("call push, flags or timing wrong");
	chk_clear_mem: assert property (exec && op == OP_CLRM && arg < 8'(`IXA_MEM_WORDS)
		|=> r.mem[$past(arg[6:0])] == 8'h00) // RULE_13
		else $error("clear memory left bits set");

endmodule : ixa_exec

// file: ixa_defs.svh
`ifndef IXA_DEFS_SVH
`define IXA_DEFS_SVH

// Register byte offsets on the Wishbone port.
`define IXA_OFS_INSTR 8'h00
`define IXA_OFS_STATUS 8'h04
`define IXA_OFS_ACC 8'h08
`define IXA_OFS_PC 8'h0C
`define IXA_OFS_CYCLES 8'h10
`define IXA_OFS_STACK 8'h14
`define IXA_OFS_MEMADDR 8'h18
`define IXA_OFS_MEMDATA 8'h1C

// Instruction register fields.
`define IXA_IR_OP_LSB 0
`define IXA_IR_OP_MSB 3
`define IXA_IR_ARG_LSB 8
`define IXA_IR_ARG_MSB 15
`define IXA_IR_TGT_LSB 16
`define IXA_IR_TGT_MSB 26

// Status register bit positions.
`define IXA_ST_C 0
`define IXA_ST_AC 1
`define IXA_ST_Z 2
`define IXA_ST_OV 3
`define IXA_ST_PDF 4
`define IXA_ST_TO 5
`define IXA_ST_BUSY 8

// Sizes, special addresses and reset values.
`define IXA_PC_W 11
`define IXA_MEM_WORDS 96
`define IXA_STACK_DEPTH 6
`define IXA_PCL_ADDR 8'h60
`define IXA_RST_ACC 8'h00
`define IXA_RST_PC 11'h000
`define IXA_RST_FLAG 1'b0

// Instruction cycle counts.
`define IXA_CYC_ONE 2'h1
`define IXA_CYC_TWO 2'h2

`endif

// file: ixa_pkg.sv
`include "ixa_defs.svh"

package ixa_pkg;

	// Decoded operations carried in the instruction register.
	typedef enum logic [3:0] {
		OP_NOP = 4'h0,
		OP_ADC = 4'h1,
		OP_ADCM = 4'h2,
		OP_ADD = 4'h3,
		OP_ADDI = 4'h4,
		OP_ADDM = 4'h5,
		OP_AND = 4'h6,
		OP_ANDI = 4'h7,
		OP_ANDM = 4'h8,
		OP_CALL = 4'h9,
		OP_CLRM = 4'hA,
		OP_WDT1 = 4'hB,
		OP_WDT2 = 4'hC,
		OP_SZ = 4'hD
	} ixa_op_t;

	// Execution sequence, Gray coded along idle, first and second cycle.
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_EXEC = 2'h1,
		ST_EXEC2 = 2'h3
	} ixa_st_t;

	// Which watchdog pre-clear ran last.
	typedef enum logic [1:0] {
		WDT_NONE = 2'h0,
		WDT_FIRST = 2'h1,
		WDT_SECOND = 2'h2
	} ixa_wdt_t;

	// Whole state of the executor.
	typedef struct packed {
		ixa_st_t st;
		logic [31:0] ir;
		logic [7:0] accumulator;
		logic [`IXA_PC_W-1:0] pc;
		logic carry_flag;
		logic aux_carry_flag;
		logic zero_flag;
		logic overflow_flag;
		logic powerdown_flag;
		logic timeout_flag;
		ixa_wdt_t wdt;
		logic [1:0] cycles;
		logic [2:0] depth;
		logic [`IXA_STACK_DEPTH-1:0][`IXA_PC_W-1:0] stack;
		logic [7:0] maddr;
		logic [`IXA_MEM_WORDS-1:0][7:0] mem;
		logic ack;
		logic [31:0] dat;
	} ixa_state_t;

endpackage : ixa_pkg

// file: ixa_alu_if.sv
`timescale 1ns/1ps

// Operands and results between the executor and its adder.
interface ixa_alu_if;
	logic [7:0] a;
	logic [7:0] b;
	logic cin;
	logic is_and;
	logic [7:0] res;
	logic cout;
	logic acout;
	logic ovf;

	modport exec (output a, output b, output cin, output is_and,
		input res, input cout, input acout, input ovf);
	modport alu (input a, input b, input cin, input is_and,
		output res, output cout, output acout, output ovf);
endinterface : ixa_alu_if

// file: ixa_alu.sv
`timescale 1ns/1ps

module ixa_alu
	import ixa_pkg::*;
(
	// Operand and result bundle.
	ixa_alu_if.alu alu
);

	logic [8:0] sum;
	logic [4:0] low;

	// Full and low-nibble sums; the nibble sum yields the half carry.
	assign sum = {1'b0, alu.a} + {1'b0, alu.b} + {8'h00, alu.cin};
	assign low = {1'b0, alu.a[3:0]} + {1'b0, alu.b[3:0]} + {4'h0, alu.cin};

	// Overflow is a sign change that both operands did not share.
	assign alu.res = alu.is_and ? (alu.a & alu.b) : sum[7:0];
	assign alu.cout = sum[8]; // RULE_14
	assign alu.acout = low[4];
	assign alu.ovf = (alu.a[7] == alu.b[7]) && (sum[7] != alu.a[7]);

endmodule : ixa_alu

// file: tb.sv
`timescale 1ns/1ps
`include "ixa_defs.svh"

module tb
	import ixa_pkg::*;
;
	// Bus drive, design answers and bookkeeping.
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic [31:0] seed = 32'h3A9B;
	int error_cnt = 0;
	int checked = 0;
	// Reference model: flags are {timeout, powerdown, overflow, zero, half carry, carry}.
	int accu, pc, cyc, last;
	logic [5:0] fl;
	int mem [96];
	int stk [$];
	ixa_op_t ops [11] = '{OP_ADC, OP_ADCM, OP_ADD, OP_ADDI, OP_ADDM, OP_AND, OP_ANDI,
		OP_ANDM, OP_CALL, OP_CLRM, OP_SZ};
	ixa_op_t wseq [6] = '{OP_WDT1, OP_WDT1, OP_WDT2, OP_NOP, OP_WDT2, OP_WDT1};

	// Free running 25 MHz clock.
	always #20 clk_i = ~clk_i;

	ixa_exec ixa_exec_i (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o)
	);

	// Xorshift source; every random value reaches the bus.
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	// Prints the counts and the verdict, then ends the run.
	task automatic report_and_stop();
		$display("checked %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : report_and_stop

	// One classic cycle, entered just after an edge; the ack is awaited under a bound.
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 8);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (n >= 8)
		begin
			error_cnt++;
			$display("MISMATCH ack expected 1 seen 0");
		end
		// Strobe stays low across one edge so the next access is a fresh request.
		@(posedge clk_i);
	endtask : wb

	// Reads one word and compares the masked bits with the model.
	task automatic chk(input string s, input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		checked++;
		if ((q & m) !== (e & m))
		begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", s, e & m, q & m);
		end
	endtask : chk

	// Data space as the model sees it; the low program counter byte sits at 60h.
	function automatic int rdm(input int a);
		return a < 96 ? mem[a] : (a == 96 ? pc & 32'hFF : 0);
	endfunction : rdm

	// Reads back every visible result of the last instruction.
	task automatic ck(input logic [7:0] a);
		logic [31:0] q;
		int d;
		int t;
		d = stk.size();
		t = d ? stk[$] : 0;
		chk("accumulator", `IXA_OFS_ACC, accu, 32'hFF);
		chk("status", `IXA_OFS_STATUS, fl, 32'hFFFFFFFF);
		chk("pc", `IXA_OFS_PC, pc, 32'h7FF);
		chk("cycles", `IXA_OFS_CYCLES, cyc, 32'h3);
		chk("stack", `IXA_OFS_STACK, (d << 16) | t, d ? 32'h707FF : 32'h70000);
		wb(1'b1, `IXA_OFS_MEMADDR, {24'h0, a}, q);
		chk("memory", `IXA_OFS_MEMDATA, rdm(a), 32'hFF);
	endtask : ck

	// Seeds accumulator, flags and one memory byte over the bus.
	task automatic sd(input logic [7:0] av, input logic [5:0] st, input logic [7:0] a,
		input logic [7:0] v);
		logic [31:0] q;
		wb(1'b1, `IXA_OFS_ACC, {24'h0, av}, q);
		wb(1'b1, `IXA_OFS_STATUS, {26'h0, st}, q);
		wb(1'b1, `IXA_OFS_MEMADDR, {24'h0, a}, q);
		wb(1'b1, `IXA_OFS_MEMDATA, {24'h0, v}, q);
		accu = av;
		fl = st;
		// A seed aimed at 60h lands in the low program counter byte, not in RAM.
		if (a < 96)
			mem[a] = v;
		else if (a == 96)
			pc = (pc & 32'h700) | v;
	endtask : sd

	// Launches one instruction, steps the model, then compares everything.
	task automatic run(input ixa_op_t op, input logic [7:0] arg, input logic [10:0] tg);
		logic [31:0] q;
		int b;
		int r;
		int ci;
		int np;
		wb(1'b1, `IXA_OFS_INSTR, {5'h00, tg, arg, 4'h0, op}, q);
		b = (op inside {OP_ADDI, OP_ANDI}) ? arg : rdm(arg);
		ci = (op inside {OP_ADC, OP_ADCM}) ? fl[0] : 0;
		r = accu + b + ci;
		np = pc + 1;
		cyc = 1;
		if (op inside {OP_ADC, OP_ADCM, OP_ADD, OP_ADDI, OP_ADDM})
			fl[3:0] = {|((accu ^ r) & (b ^ r) & 32'h80), r[7:0] == 8'h00,
				(accu % 16 + b % 16 + ci) > 15, r > 255};
		if (op inside {OP_AND, OP_ANDI, OP_ANDM})
		begin
			r = accu & b;
			fl[2] = r == 0;
		end
		if (op inside {OP_ADC, OP_ADD, OP_ADDI, OP_AND, OP_ANDI})
			accu = r & 32'hFF;
		if (op == OP_CALL)
		begin
			stk.push_back(np & 32'h7FF);
			if (stk.size() > 6)
				stk.pop_front();
			np = tg;
			cyc = 2;
		end
		if (op == OP_SZ && b == 0)
		begin
			np++;
			cyc = 2;
		end
		// Only a pre-clear directly after the other kind clears the pair.
		if (op inside {OP_WDT1, OP_WDT2} && last != 0 && last != op)
			fl[5:4] = 2'b00;
		last = (op inside {OP_WDT1, OP_WDT2}) ? op : 0;
		pc = np & 32'h7FF;
		// A store to 60h replaces the low program counter byte and costs a cycle.
		if (op inside {OP_ADCM, OP_ADDM, OP_ANDM, OP_CLRM} && arg < 96)
			mem[arg] = (op == OP_CLRM) ? 0 : r & 32'hFF;
		else if (op inside {OP_ADCM, OP_ADDM, OP_ANDM, OP_CLRM} && arg == 96)
		begin
			pc = ((np - 1) & 32'h700) | ((op == OP_CLRM) ? 0 : r & 32'hFF);
			cyc = 2;
		end
		ck(arg);
	endtask : run

	// Holds reset for eight cycles and clears the model.
	task automatic rst();
		rst_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		accu = 0;
		pc = 0;
		cyc = 0;
		last = 0;
		fl = 6'h00;
		foreach (mem[i])
			mem[i] = 0;
		stk.delete();
	endtask : rst

	// Main sequence: reset values, random operations, program counter stores, calls,
	// pre-clear pairing and a second reset.
	initial
	begin
		logic [31:0] r1;
		logic [31:0] r2;
		logic [31:0] q;
		logic [7:0] arg;
		int k;
		rst();
		ck(8'h00);
		wb(1'b1, 8'h20, 32'hFFFFFFFF, q);
		chk("unmapped", 8'h20, 32'h0, 32'hFFFFFFFF);
		repeat (150)
		begin
			r1 = rnd();
			r2 = rnd();
			k = r2[23:16] % 11;
			arg = (ops[k] inside {OP_ADDI, OP_ANDI}) ? r2[31:24] : 8'(r2[7:0] % 96);
			// A zero byte one time in eight lets the skip be taken.
			sd(r1[7:0], r1[13:8], arg, (r1[20:18] != 3'h0) ? r2[15:8] : 8'h00);
			run(ops[k], arg, r1[31:21]);
		end
		run(OP_CALL, 8'h00, 11'h234);
		sd(8'h1C, 6'h00, 8'h00, 8'h00);
		run(OP_ADDM, 8'h60, 11'h000);
		run(OP_CLRM, 8'h60, 11'h000);
		// More calls than stack entries, so the oldest return address is dropped.
		repeat (7)
		begin
			r1 = rnd();
			run(OP_CALL, 8'h00, r1[10:0]);
		end
		foreach (wseq[i])
		begin
			sd(8'h00, 6'h3F, 8'h00, 8'h00);
			run(wseq[i], 8'h00, 11'h000);
		end
		rst();
		ck(8'h00);
		report_and_stop();
	end

	// Watchdog well beyond the expected run length.
	initial
	begin
		#2000000;
		error_cnt++;
		report_and_stop();
	end

endmodule : tb
